// [rtl/plc_pkg.sv]
// Package: register map, field layouts and constants of the PLL status block
package plc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [9:0] ADDR_STAT_ABL = 10'h017;
  localparam logic [9:0] ADDR_REF_LOCK = 10'h018;
  localparam logic [7:0] RST_STAT_ABL = 8'h00;
  localparam logic [7:0] RST_REF_LOCK = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int STAT_SEL_LSB = 2;
  localparam int STAT_SEL_MSB = 7;
  localparam int ABL_LSB = 0;
  localparam int ABL_MSB = 1;
  localparam int DC_OFS_BIT = 7;
  localparam int LOCK_CNT_LSB = 5;
  localparam int LOCK_CNT_MSB = 6;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [5:0] STAT_SEL_HOLDOVER = 6'h3e;
  localparam logic [5:0] STAT_SEL_LOCK_CMP = 6'h3f;
  localparam logic [1:0] ABL_2P9A = 2'h0;
  localparam logic [1:0] ABL_1P3 = 2'h1;
  localparam logic [1:0] ABL_6P0 = 2'h2;
  localparam logic [1:0] ABL_2P9B = 2'h3;
  // Antibacklash widths in picoseconds
  localparam logic [15:0] ABL_PS_2P9 = 16'h0b54;
  localparam logic [15:0] ABL_PS_1P3 = 16'h0514;
  localparam logic [15:0] ABL_PS_6P0 = 16'h1770;
  localparam logic [1:0] LOCK_CNT_DEF = 2'h0;
  localparam logic [7:0] LOCK_CYC_DEF = 8'h05;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic wr_en;
    logic [9:0] addr;
    logic [7:0] wdata;
  } plc_reg_req_s;

  typedef struct packed {
    logic cycle_stb;
    logic in_window;
  } plc_pfd_ev_s;

endpackage : plc_pkg

// [rtl/plc_lock_cnt.sv]
// Lock detect run counter of consecutive in-window detector cycles
module plc_lock_cnt #(
  parameter int CW = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire plc_pkg::plc_pfd_ev_s pfd_ev,
  input wire logic [CW-1:0] threshold,
  output logic locked,
  output logic [CW-1:0] run_count
);

  // Counter must reach the default threshold of five
  if (CW < 3) begin : g_cw_chk
    $error("plc_lock_cnt: CW too small");
  end

  typedef struct packed {
    logic [CW-1:0] run;
    logic locked;
  } plc_cnt_state_s;

  plc_cnt_state_s st_ff;
  plc_cnt_state_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (pfd_ev.cycle_stb) begin
      if (!pfd_ev.in_window) begin
        nxt_st.run = '0;
        nxt_st.locked = 1'b0;
      end else begin
        if (st_ff.run != '1) begin
          nxt_st.run = st_ff.run + CW'(1);
        end
        if (st_ff.run + CW'(1) >= threshold) begin
          nxt_st.locked = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign locked = st_ff.locked;
  assign run_count = st_ff.run;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_lock_needs_run;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(locked) |-> $past(pfd_ev.cycle_stb) && $past(pfd_ev.in_window)
      && ($past(run_count) + 1 >= $past(threshold));
  endproperty
  a_lock_needs_run: assert property (p_lock_needs_run)
    else $error("lock declared without enough in-window cycles");

  property p_miss_restarts;
    @(posedge clk_sys) disable iff (!rst_n)
    pfd_ev.cycle_stb && !pfd_ev.in_window |=> run_count == '0 && !locked;
  endproperty
  a_miss_restarts: assert property (p_miss_restarts)
    else $error("out-of-window cycle did not restart the count");

  property p_lock_holds;
    @(posedge clk_sys) disable iff (!rst_n)
    locked && !(pfd_ev.cycle_stb && !pfd_ev.in_window) |=> locked;
  endproperty
  a_lock_holds: assert property (p_lock_holds)
    else $error("lock dropped without an out-of-window cycle");

  property p_cov_lock;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(locked);
  endproperty
  c_cov_lock: cover property (p_cov_lock);

  property p_cov_unlock;
    @(posedge clk_sys) disable iff (!rst_n)
    $fell(locked);
  endproperty
  c_cov_unlock: cover property (p_cov_unlock);

endmodule : plc_lock_cnt

// [rtl/plc_status_lock.sv]
// PLL status pin select, antibacklash, dc offset and lock detect settings
//
// Contract
// - Code 111110 puts active-low holdover on status.
// - Code 111111 puts active-low lock comparator on status.
// - Bits [1:0] pick antibacklash width 2.9/1.3/6.0/2.9.
// - Bit 7 of 0x018 enables reference dc offset.
// - Lock after N consecutive in-window cycles, default five.
module plc_status_lock #(
  parameter logic [7:0] LOCK_CYC_01 = 8'h10,
  parameter logic [7:0] LOCK_CYC_10 = 8'h40,
  parameter logic [7:0] LOCK_CYC_11 = 8'hff
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire plc_pkg::plc_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  input wire logic holdover_active,
  input wire logic lock_cmp_out,
  input wire plc_pkg::plc_pfd_ev_s pfd_ev,
  output logic status_pin_n,
  output logic [1:0] abl_width_sel,
  output logic [15:0] abl_width_ps,
  output logic dc_offset_en,
  output logic pll_locked
);

  // Zero threshold would declare lock on the first in-window cycle, the same as a threshold of one
  if (LOCK_CYC_01 == 8'h00 || LOCK_CYC_10 == 8'h00 ||
      LOCK_CYC_11 == 8'h00) begin : g_cyc_chk
    $error("plc_status_lock: lock cycle count must be nonzero");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] stat_abl;
    logic [7:0] ref_lock;
    logic [7:0] rdata;
    logic status_n;
    logic [15:0] abl_ps;
  } plc_state_s;

  plc_state_s st_ff;
  plc_state_s nxt_st;
  logic [5:0] stat_sel;
  logic [1:0] abl_code;
  logic [1:0] lock_code;
  logic [7:0] lock_thr;
  logic [7:0] run_count;
  logic [1:0] wr_abl_code;

  assign stat_sel =
    st_ff.stat_abl[plc_pkg::STAT_SEL_MSB:plc_pkg::STAT_SEL_LSB];
  assign abl_code = st_ff.stat_abl[plc_pkg::ABL_MSB:plc_pkg::ABL_LSB];
  assign lock_code =
    st_ff.ref_lock[plc_pkg::LOCK_CNT_MSB:plc_pkg::LOCK_CNT_LSB];
  // Width code on the write bus, for the checks only
  assign wr_abl_code = reg_req.wdata[plc_pkg::ABL_MSB:plc_pkg::ABL_LSB];

  // ****************************************************************
  // Lock threshold decode
  // ****************************************************************
  always_comb begin
    case (lock_code)
      plc_pkg::LOCK_CNT_DEF: lock_thr = plc_pkg::LOCK_CYC_DEF;
      2'h1: lock_thr = LOCK_CYC_01;
      2'h2: lock_thr = LOCK_CYC_10;
      default: lock_thr = LOCK_CYC_11;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    if (reg_req.wr_en && reg_req.addr == plc_pkg::ADDR_STAT_ABL) begin
      nxt_st.stat_abl = reg_req.wdata;
    end
    if (reg_req.wr_en && reg_req.addr == plc_pkg::ADDR_REF_LOCK) begin
      nxt_st.ref_lock = reg_req.wdata;
    end
    case (reg_req.addr)
      plc_pkg::ADDR_STAT_ABL: nxt_st.rdata = st_ff.stat_abl;
      plc_pkg::ADDR_REF_LOCK: nxt_st.rdata = st_ff.ref_lock;
      default: nxt_st.rdata = 8'h00;
    endcase
    case (stat_sel)
      plc_pkg::STAT_SEL_HOLDOVER: begin
        nxt_st.status_n = ~holdover_active;
      end
      plc_pkg::STAT_SEL_LOCK_CMP: nxt_st.status_n = ~lock_cmp_out;
      default: nxt_st.status_n = 1'b1;
    endcase
    case (abl_code)
      plc_pkg::ABL_1P3: nxt_st.abl_ps = plc_pkg::ABL_PS_1P3;
      plc_pkg::ABL_6P0: nxt_st.abl_ps = plc_pkg::ABL_PS_6P0;
      default: nxt_st.abl_ps = plc_pkg::ABL_PS_2P9;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff.stat_abl <= plc_pkg::RST_STAT_ABL;
      st_ff.ref_lock <= plc_pkg::RST_REF_LOCK;
      st_ff.rdata <= 8'h00;
      st_ff.status_n <= 1'b1;
      st_ff.abl_ps <= plc_pkg::ABL_PS_2P9;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Lock detect counter
  // ****************************************************************
  plc_lock_cnt #(
    .CW(8)
  ) u_lock_cnt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pfd_ev(pfd_ev),
    .threshold(lock_thr),
    .locked(pll_locked),
    .run_count(run_count)
  );

  assign reg_rdata = st_ff.rdata;
  assign status_pin_n = st_ff.status_n;
  assign abl_width_sel = abl_code;
  assign abl_width_ps = st_ff.abl_ps;
  assign dc_offset_en = st_ff.ref_lock[plc_pkg::DC_OFS_BIT];

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_stat_holdover;
    @(posedge clk_sys) disable iff (!rst_n)
    stat_sel == plc_pkg::STAT_SEL_HOLDOVER |=>
      status_pin_n == !$past(holdover_active);
  endproperty
  a_stat_holdover: assert property (p_stat_holdover)
    else $error("status pin does not follow holdover");

  property p_stat_lock_cmp;
    @(posedge clk_sys) disable iff (!rst_n)
    stat_sel == plc_pkg::STAT_SEL_LOCK_CMP |=>
      status_pin_n == !$past(lock_cmp_out);
  endproperty
  a_stat_lock_cmp: assert property (p_stat_lock_cmp)
    else $error("status pin does not follow lock comparator");

  property p_abl_width;
    @(posedge clk_sys) disable iff (!rst_n)
    reg_req.wr_en && reg_req.addr == plc_pkg::ADDR_STAT_ABL ##1
      !reg_req.wr_en |=>
      abl_width_ps ==
        ($past(wr_abl_code, 2) == plc_pkg::ABL_1P3 ? plc_pkg::ABL_PS_1P3 :
         $past(wr_abl_code, 2) == plc_pkg::ABL_6P0 ? plc_pkg::ABL_PS_6P0 :
         plc_pkg::ABL_PS_2P9);
  endproperty
  a_abl_width: assert property (p_abl_width)
    else $error("antibacklash width does not match code");

  property p_dc_offset;
    @(posedge clk_sys) disable iff (!rst_n)
    reg_req.wr_en && reg_req.addr == plc_pkg::ADDR_REF_LOCK |=>
      dc_offset_en == $past(reg_req.wdata[plc_pkg::DC_OFS_BIT]);
  endproperty
  a_dc_offset: assert property (p_dc_offset)
    else $error("dc offset enable does not follow write");

  property p_default_five;
    @(posedge clk_sys) disable iff (!rst_n)
    lock_code == plc_pkg::LOCK_CNT_DEF && $rose(pll_locked) |->
      $past(run_count) >= plc_pkg::LOCK_CYC_DEF - 8'h01;
  endproperty
  a_default_five: assert property (p_default_five)
    else $error("default lock came before five cycles");

  // Other select codes leave the status pin inactive
  property p_stat_idle;
    @(posedge clk_sys) disable iff (!rst_n)
    stat_sel != plc_pkg::STAT_SEL_HOLDOVER &&
      stat_sel != plc_pkg::STAT_SEL_LOCK_CMP |=> status_pin_n;
  endproperty
  a_stat_idle: assert property (p_stat_idle)
    else $error("status pin active for an unused select code");

  property p_ref_read_back;
    @(posedge clk_sys) disable iff (!rst_n)
    reg_req.wr_en && reg_req.addr == plc_pkg::ADDR_REF_LOCK ##1
      reg_req.addr == plc_pkg::ADDR_REF_LOCK |=>
      reg_rdata == $past(reg_req.wdata, 2);
  endproperty
  a_ref_read_back: assert property (p_ref_read_back)
    else $error("reference register read back differs from write");

  // Reset defaults, seen at the edge after a reset edge
  property p_rst_abl;
    @(posedge clk_sys)
    !rst_n |=> abl_width_ps == plc_pkg::ABL_PS_2P9 &&
      abl_width_sel == plc_pkg::ABL_2P9A;
  endproperty
  a_rst_abl: assert property (p_rst_abl)
    else $error("antibacklash width not at default after reset");

  property p_rst_dc;
    @(posedge clk_sys)
    !rst_n |=> !dc_offset_en;
  endproperty
  a_rst_dc: assert property (p_rst_dc)
    else $error("dc offset enabled after reset");

  property p_rst_lock;
    @(posedge clk_sys)
    !rst_n |=> !pll_locked;
  endproperty
  a_rst_lock: assert property (p_rst_lock)
    else $error("lock indicated after reset");

  property p_cov_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    stat_sel == plc_pkg::STAT_SEL_HOLDOVER && !status_pin_n;
  endproperty
  c_cov_hold: cover property (p_cov_hold);

  property p_cov_lock_cmp;
    @(posedge clk_sys) disable iff (!rst_n)
    stat_sel == plc_pkg::STAT_SEL_LOCK_CMP && !status_pin_n;
  endproperty
  c_cov_lock_cmp: cover property (p_cov_lock_cmp);

  property p_cov_abl_wide;
    @(posedge clk_sys) disable iff (!rst_n)
    abl_width_ps == plc_pkg::ABL_PS_6P0;
  endproperty
  c_cov_abl_wide: cover property (p_cov_abl_wide);

endmodule : plc_status_lock

// [sim/plc_status_lock_tb.sv]
// Self-checking testbench of the PLL status and lock detect block
module plc_status_lock_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Signals and design instance
  // ****************************************************************
  localparam logic [7:0] CYC_01 = 8'h07;
  localparam logic [7:0] CYC_10 = 8'h09;
  localparam logic [7:0] CYC_11 = 8'h0b;
  localparam int TIMEOUT_CYC = 5000;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  plc_pkg::plc_reg_req_s reg_req = '0;
  plc_pkg::plc_pfd_ev_s pfd_ev = '0;
  logic holdover_active = 1'b0;
  logic lock_cmp_out = 1'b0;
  logic [7:0] reg_rdata;
  logic status_pin_n;
  logic [1:0] abl_width_sel;
  logic [15:0] abl_width_ps;
  logic dc_offset_en;
  logic pll_locked;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc_cnt = 0;

  always #5 clk_sys = ~clk_sys;

  plc_status_lock #(
    .LOCK_CYC_01(CYC_01),
    .LOCK_CYC_10(CYC_10),
    .LOCK_CYC_11(CYC_11)
  ) uut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .holdover_active(holdover_active),
    .lock_cmp_out(lock_cmp_out),
    .pfd_ev(pfd_ev),
    .status_pin_n(status_pin_n),
    .abl_width_sel(abl_width_sel),
    .abl_width_ps(abl_width_ps),
    .dc_offset_en(dc_offset_en),
    .pll_locked(pll_locked)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt == TIMEOUT_CYC) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask : step

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    step();
    reg_req.wr_en = 1'b1;
    reg_req.addr = a;
    reg_req.wdata = d;
    step();
    reg_req.wr_en = 1'b0;
    repeat (2) step();
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    step();
    reg_req.addr = a;
    step();
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask : rd

  // Back-to-back detector strobes, then settle
  task automatic stbs(input int n, input logic inw);
    repeat (n) begin
      step();
      pfd_ev.cycle_stb = 1'b1;
      pfd_ev.in_window = inw;
    end
    step();
    pfd_ev = '0;
    repeat (2) step();
  endtask : stbs

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(plc_pkg::ADDR_STAT_ABL, 8'h00);
    rd(plc_pkg::ADDR_REF_LOCK, 8'h00);
    chk({15'h0000, status_pin_n}, 16'h0001);
    chk(abl_width_ps, plc_pkg::ABL_PS_2P9);
    chk({15'h0000, dc_offset_en}, 16'h0000);
    chk({15'h0000, pll_locked}, 16'h0000);
  endtask : t_reset

  task automatic t_status();
    logic [5:0] codes [3] = '{6'h3e, 6'h3f, 6'h3d};
    for (int c = 0; c < 3; c++) begin
      wr(plc_pkg::ADDR_STAT_ABL, {codes[c], 2'b00});
      for (int v = 0; v < 4; v++) begin
        holdover_active = v[0];
        lock_cmp_out = v[1];
        repeat (2) step();
        if (c == 0) begin
          chk({15'h0000, status_pin_n}, {15'h0000, ~v[0]});
        end else if (c == 1) begin
          chk({15'h0000, status_pin_n}, {15'h0000, ~v[1]});
        end else begin
          chk({15'h0000, status_pin_n}, 16'h0001);
        end
      end
    end
    rd(plc_pkg::ADDR_STAT_ABL, 8'hf4);
  endtask : t_status

  task automatic t_abl();
    logic [15:0] ps [4] = '{plc_pkg::ABL_PS_2P9, plc_pkg::ABL_PS_1P3,
                           plc_pkg::ABL_PS_6P0, plc_pkg::ABL_PS_2P9};
    for (int i = 0; i < 4; i++) begin
      wr(plc_pkg::ADDR_STAT_ABL, {6'h3e, i[1:0]});
      chk({14'h0000, abl_width_sel}, {14'h0000, i[1:0]});
      chk(abl_width_ps, ps[i]);
    end
  endtask : t_abl

  task automatic t_dc();
    wr(plc_pkg::ADDR_REF_LOCK, 8'h80);
    chk({15'h0000, dc_offset_en}, 16'h0001);
    wr(10'h019, 8'hff);
    rd(10'h019, 8'h00);
    rd(plc_pkg::ADDR_REF_LOCK, 8'h80);
    wr(plc_pkg::ADDR_REF_LOCK, 8'h00);
    chk({15'h0000, dc_offset_en}, 16'h0000);
  endtask : t_dc

  task automatic t_lock();
    logic [7:0] n [4] = '{plc_pkg::LOCK_CYC_DEF, CYC_01, CYC_10, CYC_11};
    stbs(4, 1'b1);
    pfd_ev.in_window = 1'b1;
    repeat (3) step();
    pfd_ev.in_window = 1'b0;
    chk({15'h0000, pll_locked}, 16'h0000);
    stbs(1, 1'b1);
    chk({15'h0000, pll_locked}, 16'h0001);
    stbs(1, 1'b0);
    chk({15'h0000, pll_locked}, 16'h0000);
    stbs(4, 1'b1);
    stbs(1, 1'b0);
    stbs(4, 1'b1);
    chk({15'h0000, pll_locked}, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      wr(plc_pkg::ADDR_REF_LOCK, {1'b0, c[1:0], 5'h00});
      stbs(1, 1'b0);
      stbs(int'(n[c]) - 1, 1'b1);
      chk({15'h0000, pll_locked}, 16'h0000);
      stbs(1, 1'b1);
      chk({15'h0000, pll_locked}, 16'h0001);
    end
  endtask : t_lock

  // Reset in mid-run, from a locked and configured state
  task automatic t_rst_mid();
    wr(plc_pkg::ADDR_STAT_ABL, 8'hfa);
    wr(plc_pkg::ADDR_REF_LOCK, 8'he0);
    chk(abl_width_ps, plc_pkg::ABL_PS_6P0);
    chk({15'h0000, dc_offset_en}, 16'h0001);
    chk({15'h0000, pll_locked}, 16'h0001);
    rst_n = 1'b0;
    repeat (2) step();
    rst_n = 1'b1;
    chk({15'h0000, pll_locked}, 16'h0000);
    chk(abl_width_ps, plc_pkg::ABL_PS_2P9);
    chk({15'h0000, dc_offset_en}, 16'h0000);
    chk({15'h0000, status_pin_n}, 16'h0001);
    rd(plc_pkg::ADDR_STAT_ABL, 8'h00);
    rd(plc_pkg::ADDR_REF_LOCK, 8'h00);
  endtask : t_rst_mid

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_status();
    t_abl();
    t_dc();
    t_lock();
    t_rst_mid();
    test_done();
  end

endmodule : plc_status_lock_tb
